// *** core/trc_cmd_port.sv ***
/*
 * trc_cmd_port: host command interpreter of the tag reader.
 * assumes raw serial pins from the host and a one-cycle tag read strobe
 * from the reader logic on the same clock.
 */
`timescale 1ns/100ps
module trc_cmd_port
#(
    parameter int BIT_CYCLES = trc_pkg::BIT_CYCLES,
    parameter int LOCK_CYCLES = trc_pkg::LOCK_CYCLES
)
(
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // serial link to host
    input wire logic RXD_I,
    input wire logic CTS_I,
    input wire logic HANDSHAKE_EN_I,
    output logic TXD_O,
    output logic RTS_O,
    // reader interface
    input wire logic TAG_READ_I,
    input wire logic FACTORY_RESET_I,
    output logic CMD_MODE_O,
    output logic DUAL_MODE_O,
    output logic RF_ON_O,
    output logic LOCK_O
);
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} trc_rx_t;
    typedef enum {MS_SIGNON, MS_IDLE, MS_SEND} trc_msg_t;

    ////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds the second only
    logic rxd_s1_reg, rxd_s2_reg, cts_s1_reg, cts_s2_reg;
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            rxd_s1_reg <= 1'b1;
            rxd_s2_reg <= 1'b1;
            cts_s1_reg <= 1'b0;
            cts_s2_reg <= 1'b0;
        end
        else
        begin
            rxd_s1_reg <= RXD_I;
            rxd_s2_reg <= rxd_s1_reg;
            cts_s1_reg <= CTS_I;
            cts_s2_reg <= cts_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // receiver: mid-bit sampling, stop bit checked
    trc_rx_t rx_reg, rx_next;
    logic [15:0] rt_reg, rt_next;
    logic [2:0] rb_reg, rb_next;
    logic [7:0] rd_reg, rd_next;
    logic rv_reg, rv_next;
    always_comb
    begin
        rx_next = rx_reg;
        rt_next = rt_reg;
        rb_next = rb_reg;
        rd_next = rd_reg;
        rv_next = 1'b0;
        case (rx_reg)
            RX_IDLE:
                if (!rxd_s2_reg)
                begin
                    rx_next = RX_START;
                    rt_next = 16'(BIT_CYCLES / 2 - 1);
                end
            RX_START:
                if (rt_reg != 16'h0000)
                    rt_next = rt_reg - 16'h0001;
                else if (rxd_s2_reg)
                    rx_next = RX_IDLE; // glitch, not a start bit
                else
                begin
                    rx_next = RX_DATA;
                    rt_next = 16'(BIT_CYCLES - 1);
                    rb_next = 3'h0;
                end
            RX_DATA:
                if (rt_reg != 16'h0000)
                    rt_next = rt_reg - 16'h0001;
                else
                begin
                    rd_next = {rxd_s2_reg, rd_reg[7:1]};
                    rt_next = 16'(BIT_CYCLES - 1);
                    rb_next = rb_reg + 3'h1;
                    if (rb_reg == 3'h7)
                        rx_next = RX_STOP;
                end
            RX_STOP:
                if (rt_reg != 16'h0000)
                    rt_next = rt_reg - 16'h0001;
                else
                begin
                    rx_next = RX_IDLE;
                    rv_next = rxd_s2_reg; // framing error drops the byte
                end
            default:
                rx_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            rx_reg <= RX_IDLE;
            rt_reg <= 16'h0000;
            rb_reg <= 3'h0;
            rd_reg <= 8'h00;
            rv_reg <= 1'b0;
        end
        else
        begin
            rx_reg <= rx_next;
            rt_reg <= rt_next;
            rb_reg <= rb_next;
            rd_reg <= rd_next;
            rv_reg <= rv_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // command collector, decoder and mode state
    logic [31:0] buf_reg, buf_next;
    logic [2:0] bl_reg, bl_next;
    logic inc_reg, inc_next;
    logic cmd_reg, cmd_next, dual_reg, dual_next, rf_reg, rf_next;
    logic done_req;
    trc_msg_t ms_reg, ms_next;
    always_comb
    begin
        buf_next = buf_reg;
        bl_next = bl_reg;
        inc_next = inc_reg;
        cmd_next = cmd_reg;
        dual_next = dual_reg;
        rf_next = rf_reg;
        done_req = 1'b0;
        // nothing is taken until the sign-on is out
        if (rv_reg && ms_reg != MS_SIGNON)
        begin
            if (rd_reg == trc_pkg::CH_HASH)
            begin
                inc_next = 1'b1;
                bl_next = 3'h0;
                buf_next = 32'h0000_0000;
            end
            else if (rd_reg == trc_pkg::CH_CR && inc_reg)
            begin
                inc_next = 1'b0;
                if (bl_reg == 3'h2 && buf_reg[15:0] == {trc_pkg::CH_0, trc_pkg::CH_1})
                begin
                    cmd_next = 1'b1;
                    done_req = 1'b1;
                end
                else if (bl_reg == 3'h2 && buf_reg[15:0] == {trc_pkg::CH_0, trc_pkg::CH_0}
                    && cmd_reg)
                begin
                    cmd_next = 1'b0;
                    done_req = 1'b1;
                end
                else if (bl_reg == 3'h3 && cmd_reg
                    && buf_reg[23:0] == {trc_pkg::CH_4, trc_pkg::CH_7, trc_pkg::CH_0})
                begin
                    dual_next = 1'b1;
                    done_req = 1'b1;
                end
                else if (bl_reg == 3'h4 && cmd_reg && buf_reg == {trc_pkg::CH_6,
                    trc_pkg::CH_4, trc_pkg::CH_0, trc_pkg::CH_1})
                begin
                    rf_next = 1'b1;
                    done_req = 1'b1;
                end
                // anything else ends silently
            end
            else if (inc_reg)
            begin
                if (bl_reg == 3'(trc_pkg::CMD_LEN))
                    bl_next = 3'h5; // overlong, never matches
                else if (bl_reg != 3'h5)
                begin
                    buf_next = {buf_reg[23:0], rd_reg};
                    bl_next = bl_reg + 3'h1;
                end
            end
        end
        // factory default last, so it wins over a dual command in the same cycle
        if (FACTORY_RESET_I)
            dual_next = trc_pkg::MODE_DUAL_RST;
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            buf_reg <= 32'h0000_0000;
            bl_reg <= 3'h0;
            inc_reg <= 1'b0;
            cmd_reg <= 1'b0;
            dual_reg <= trc_pkg::MODE_DUAL_RST;
            rf_reg <= 1'b0;
        end
        else
        begin
            buf_reg <= buf_next;
            bl_reg <= bl_next;
            inc_reg <= inc_next;
            cmd_reg <= cmd_next;
            dual_reg <= dual_next;
            rf_reg <= rf_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // reply sequencer over a constant message table
    logic [7:0] msg_rom [trc_pkg::MSG_LEN];
    assign msg_rom = '{8'h52, 8'h45, 8'h41, 8'h44, 8'h59, 8'h0D, 8'h0A, 8'h0A, 8'h0D, 8'h0A,
        8'h23, 8'h44, 8'h6F, 8'h6E, 8'h65, 8'h0D};
    logic [3:0] mp_reg, mp_next, me_reg, me_next;
    logic tx_start, tx_busy, tx_line;
    always_comb
    begin
        ms_next = ms_reg;
        mp_next = mp_reg;
        me_next = me_reg;
        tx_start = 1'b0;
        case (ms_reg)
            MS_IDLE:
                if (done_req)
                begin
                    ms_next = MS_SEND;
                    mp_next = 4'(trc_pkg::DONE_BASE);
                    me_next = 4'(trc_pkg::DONE_BASE + trc_pkg::DONE_LEN - 2);
                end
            MS_SIGNON, MS_SEND:
                if (!tx_busy)
                begin
                    tx_start = 1'b1;
                    mp_next = mp_reg + 4'h1;
                    if (mp_reg == me_reg)
                        ms_next = MS_IDLE;
                end
            default:
                ms_next = MS_IDLE;
        endcase
    end

    // last done byte (LF) comes from the CR check below
    logic send_lf_reg, send_lf_next;
    logic [7:0] tx_byte;
    always_comb
    begin
        send_lf_next = send_lf_reg;
        tx_byte = msg_rom[mp_reg];
        if (ms_reg == MS_SEND && tx_start && mp_reg == me_reg)
            send_lf_next = 1'b1;
        else if (send_lf_reg && !tx_busy)
            send_lf_next = 1'b0;
        if (send_lf_reg)
            tx_byte = trc_pkg::CH_LF;
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            ms_reg <= MS_SIGNON;
            mp_reg <= 4'h0;
            me_reg <= 4'(trc_pkg::SIGNON_LEN - 1);
            send_lf_reg <= 1'b0;
        end
        else
        begin
            ms_reg <= ms_next;
            mp_reg <= mp_next;
            me_reg <= me_next;
            send_lf_reg <= send_lf_next;
        end
    end

    // gating ignores CTS unless handshaking is enabled
    trc_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx
    (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .start_i(tx_start | (send_lf_reg & ~tx_busy)),
        .data_i(tx_byte),
        .cts_ok_i(~HANDSHAKE_EN_I | cts_s2_reg),
        .busy_o(tx_busy),
        .txd_o(tx_line)
    );

    ////////////////////////////////////////////////////////////////
    // lock pulse and output flops
    logic [31:0] lk_reg, lk_next;
    logic txd_reg, rts_reg, lock_reg;
    always_comb
    begin
        lk_next = lk_reg;
        if (TAG_READ_I)
            lk_next = 32'(LOCK_CYCLES);
        else if (lk_reg != 32'h0000_0000)
            lk_next = lk_reg - 32'h0000_0001;
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            lk_reg <= 32'h0000_0000;
            txd_reg <= 1'b1;
            rts_reg <= 1'b0;
            lock_reg <= 1'b0;
        end
        else
        begin
            lk_reg <= lk_next;
            txd_reg <= tx_line;
            rts_reg <= HANDSHAKE_EN_I;
            lock_reg <= lk_next != 32'h0000_0000;
        end
    end

    assign TXD_O = txd_reg;
    assign RTS_O = rts_reg;
    assign LOCK_O = lock_reg;
    assign CMD_MODE_O = cmd_reg;
    assign DUAL_MODE_O = dual_reg;
    assign RF_ON_O = rf_reg;

    ////////////////////////////////////////////////////////////////
    // checks
    a_lock_follows_read: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        TAG_READ_I |=> LOCK_O) else $error("lock not closed after tag read");
    a_lock_held_open: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $rose(LOCK_O) |-> $past(TAG_READ_I)) else $error("lock closed without read");
    a_factory_mode: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        FACTORY_RESET_I |=> !DUAL_MODE_O) else $error("factory reset kept dual");
    a_dual_needs_cmd: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $rose(DUAL_MODE_O) |-> $past(CMD_MODE_O)) else $error("dual set outside cmd");
    a_rf_needs_cmd: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $rose(RF_ON_O) |-> $past(CMD_MODE_O)) else $error("rf set outside cmd");
    a_enter_cmd_reply: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $rose(CMD_MODE_O) |-> $past(done_req)) else $error("cmd entry no reply");
    a_leave_cmd_reply: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $fell(CMD_MODE_O) |-> $past(done_req)) else $error("cmd exit no reply");
    a_done_starts_send: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        done_req && ms_reg == MS_IDLE |=> ms_reg == MS_SEND)
        else $error("done reply not started");
    a_signon_blocks_rx: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        ms_reg == MS_SIGNON |-> !done_req) else $error("command before sign-on");
    a_rts_follows_en: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        ##1 RTS_O == $past(HANDSHAKE_EN_I)) else $error("rts wrong");
    a_tx_idle_high: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        !tx_busy |=> TXD_O) else $error("line not idle high");
endmodule

// *** core/trc_uart_tx.sv ***
/*
 * trc_uart_tx: 8N1 serial transmitter with optional clear-to-send gating.
 * assumes cts_ok_i is already synchronised to the reference clock.
 */
`timescale 1ns/100ps
module trc_uart_tx
#(
    parameter int BIT_CYCLES = trc_pkg::BIT_CYCLES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // byte request
    input wire logic start_i,
    input wire logic [7:0] data_i,
    input wire logic cts_ok_i,
    // status and line
    output logic busy_o,
    output logic txd_o
);
    logic [9:0] sh_reg, sh_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [15:0] tim_reg, tim_next;
    logic busy_reg, busy_next;

    ////////////////////////////////////////////////////////////////
    // next state: shift start, data lsb first, stop
    always_comb
    begin
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        tim_next = tim_reg;
        busy_next = busy_reg;
        if (!busy_reg)
        begin
            // a new byte only starts while the host grants it
            if (start_i && cts_ok_i)
            begin
                sh_next = {1'b1, data_i, 1'b0};
                cnt_next = 4'h0;
                tim_next = 16'(BIT_CYCLES - 1);
                busy_next = 1'b1;
            end
        end
        else if (tim_reg != 16'h0000)
        begin
            tim_next = tim_reg - 16'h0001;
        end
        else if (cnt_reg == 4'(trc_pkg::DATA_BITS + trc_pkg::STOP_BITS))
        begin
            busy_next = 1'b0;
        end
        else
        begin
            sh_next = {1'b1, sh_reg[9:1]};
            cnt_next = cnt_reg + 4'h1;
            tim_next = 16'(BIT_CYCLES - 1);
        end
    end

    // registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sh_reg <= 10'h3FF;
            cnt_reg <= 4'h0;
            tim_reg <= 16'h0000;
            busy_reg <= 1'b0;
        end
        else
        begin
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            tim_reg <= tim_next;
            busy_reg <= busy_next;
        end
    end

    // busy from state and grant only, never from start_i, so the caller's start has no loop
    assign busy_o = busy_reg | ~cts_ok_i;
    assign txd_o = busy_reg ? sh_reg[0] : 1'b1;
endmodule

// *** dv/tb.sv ***
/*
 * tb: self-checking bench of the tag reader command port.
 * assumes the host model on the serial side and short bit and lock counts.
 */
`timescale 1ns/100ps
module tb;
    localparam int BITC = 16;
    localparam int LOCKC = 20;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic handshake_en = 1'b0;
    logic tag_read = 1'b0;
    logic factory_reset = 1'b0;
    logic rxd;
    logic cts;
    logic txd;
    logic rts;
    logic cmd_mode;
    logic dual_mode;
    logic rf_on;
    logic lock;
    int mismatches = 0;
    int n_checks = 0;

    // 20 MHz reference clock
    always #25 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // device and host
    trc_cmd_port #(.BIT_CYCLES(BITC), .LOCK_CYCLES(LOCKC)) i_dut (
        .REF_CLK_I(ref_clk), .RST_I(rst), .RXD_I(rxd), .CTS_I(cts),
        .HANDSHAKE_EN_I(handshake_en), .TXD_O(txd), .RTS_O(rts),
        .TAG_READ_I(tag_read), .FACTORY_RESET_I(factory_reset),
        .CMD_MODE_O(cmd_mode), .DUAL_MODE_O(dual_mode), .RF_ON_O(rf_on), .LOCK_O(lock));
    trc_host_model #(.BIT_CYCLES(BITC)) i_host (
        .clk_i(ref_clk), .txd_i(txd), .rts_i(rts), .rxd_o(rxd), .cts_o(cts));

    ////////////////////////////////////////////////////////////////////////////////
    // comparison and verdict
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // everything the host heard since the last look must equal s
    task expect_rx(input string s);
        check("reply length", 8'(s.len()), 8'(i_host.rx_q.size()));
        for (int i = 0; i < s.len(); i++)
            if (i_host.rx_q.size() > 0)
                check("reply byte", s[i], i_host.rx_q.pop_front());
        i_host.rx_q.delete();
    endtask

    // characters then the terminating carriage return
    task send_cmd(input string s);
        for (int i = 0; i < s.len(); i++)
            i_host.send_byte(s[i]);
        i_host.send_byte(trc_pkg::CH_CR);
    endtask

    // long enough for a seven-byte reply, so no command overlaps one
    task run_cmd(input string s, input bit answered);
        send_cmd(s);
        repeat (1300) @(posedge ref_clk);
        expect_rx(answered ? "#Done\r\n" : "");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the whole sequence
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        $display("ERROR run time expected finish seen timeout");
        test_done;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (4) @(posedge ref_clk);
        #1;
        check("txd in reset", 8'h01, txd);
        check("lock in reset", 8'h00, lock);
        @(posedge ref_clk);
        rst <= 1'b0;
        // a command during sign-on must be dropped
        send_cmd("#01");
        repeat (1300) @(posedge ref_clk);
        expect_rx("READY\r\n\n\r\n");
        check("cmd mode after sign-on", 8'h00, cmd_mode);
        check("default read mode", 8'h00, dual_mode);
        // refusals outside command mode and stray input
        run_cmd("#470", 1'b0);
        check("dual outside cmd mode", 8'h00, dual_mode);
        run_cmd("#00", 1'b0);
        run_cmd("#99", 1'b0);
        run_cmd("", 1'b0);
        // restarted command enters command mode
        run_cmd("#0#01", 1'b1);
        check("cmd mode", 8'h01, cmd_mode);
        run_cmd("#64011", 1'b0);
        check("rf after overlong", 8'h00, rf_on);
        run_cmd("#470", 1'b1);
        check("dual mode", 8'h01, dual_mode);
        // handshaking: reply held back while clear-to-send is low
        @(posedge ref_clk);
        handshake_en <= 1'b1;
        i_host.cts_allow <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check("rts", 8'h01, rts);
        send_cmd("#6401");
        repeat (1300) @(posedge ref_clk);
        check("rf on", 8'h01, rf_on);
        expect_rx("");
        i_host.cts_allow <= 1'b1;
        repeat (1300) @(posedge ref_clk);
        expect_rx("#Done\r\n");
        @(posedge ref_clk);
        handshake_en <= 1'b0;
        run_cmd("#00", 1'b1);
        check("data mode", 8'h00, cmd_mode);
        check("dual kept", 8'h01, dual_mode);
        check("rf kept", 8'h01, rf_on);
        // tag read closes the lock for the programmed time
        @(posedge ref_clk);
        tag_read <= 1'b1;
        @(posedge ref_clk);
        tag_read <= 1'b0;
        #1;
        check("lock closed", 8'h01, lock);
        repeat (LOCKC - 1) @(posedge ref_clk);
        #1;
        check("lock held", 8'h01, lock);
        @(posedge ref_clk);
        #1;
        check("lock open", 8'h00, lock);
        // factory default brings back the newer protocol only
        @(posedge ref_clk);
        factory_reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("dual after factory", 8'h00, dual_mode);
        @(posedge ref_clk);
        factory_reset <= 1'b0;
        // a second power-up sends the sign-on again and drops the modes
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (1800) @(posedge ref_clk);
        expect_rx("READY\r\n\n\r\n");
        check("cmd mode after reset", 8'h00, cmd_mode);
        check("rf after reset", 8'h00, rf_on);
        check("framing errors", 8'h00, 8'(i_host.framing_errs));
        test_done;
    end
endmodule

// *** dv/trc_host_model.sv ***
/*
 * trc_host_model: host terminal on the 8N1 serial link of the command port.
 * assumes the shared reference clock and a shortened bit time in simulation.
 */
`timescale 1ns/100ps
module trc_host_model
#(
    parameter int BIT_CYCLES = 16
)
(
    // clock
    input wire logic clk_i,
    // lines from the device
    input wire logic txd_i,
    input wire logic rts_i,
    // lines to the device
    output logic rxd_o,
    output logic cts_o
);
    logic [7:0] rx_q[$];
    logic [7:0] rx_byte;
    logic cts_allow;
    int framing_errs;

    ////////////////////////////////////////////////////////////////////////////////
    // idle line is mark, as a real terminal leaves it
    initial
    begin
        rxd_o = 1'b1;
        cts_allow = 1'b1;
        framing_errs = 0;
    end

    // clear-to-send only offered to a device that requests it
    assign cts_o = rts_i & cts_allow;

    ////////////////////////////////////////////////////////////////////////////////
    // one frame: start 0, eight bits lsb first, one stop bit
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk_i);
            rxd_o <= frame[i];
            repeat (BIT_CYCLES - 1) @(posedge clk_i);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // receiver samples mid-bit; a bad stop bit is counted, not hidden
    initial
    begin
        forever
        begin
            @(posedge clk_i);
            if (txd_i === 1'b0)
            begin
                repeat (BIT_CYCLES / 2) @(posedge clk_i);
                for (int i = 0; i < 8; i++)
                begin
                    repeat (BIT_CYCLES) @(posedge clk_i);
                    rx_byte[i] = txd_i;
                end
                repeat (BIT_CYCLES) @(posedge clk_i);
                if (txd_i !== 1'b1)
                    framing_errs++;
                rx_q.push_back(rx_byte);
            end
        end
    end
endmodule

// *** shared/trc_pkg.sv ***
/*
 * trc_pkg: constants of the tag reader host command port.
 * assumes a 20 MHz reference clock and an 8N1 serial host link.
 */
package trc_pkg;
    // clock and link timing
    localparam int CLK_HZ = 20000000;
    localparam int BAUD = 9600;
    localparam int BIT_CYCLES = (CLK_HZ + BAUD / 2) / BAUD;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    // lock output pulse length
    localparam int LOCK_MS = 100;
    localparam int LOCK_CYCLES = (CLK_HZ / 1000) * LOCK_MS;
    // characters
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_1 = 8'h31;
    localparam logic [7:0] CH_4 = 8'h34;
    localparam logic [7:0] CH_6 = 8'h36;
    localparam logic [7:0] CH_7 = 8'h37;
    // command buffer depth in characters after the hash
    localparam int CMD_LEN = 4;
    // reply message table
    localparam int MSG_LEN = 16;
    localparam int SIGNON_LEN = 10;
    localparam int DONE_LEN = 7;
    localparam int DONE_BASE = 10;
    // read mode reset value: newer tag protocol only
    localparam logic MODE_DUAL_RST = 1'b0;
endpackage
